// File: verilog/pcm_map.svh
// Register offsets, field reset values and timing figures of the audio port
`ifndef PCM_MAP_SVH
`define PCM_MAP_SVH
`define PCM_AW          5
`define PCM_REG_CTRL    5'h00
`define PCM_REG_TXDATA  5'h04
`define PCM_REG_RXDATA  5'h08
`define PCM_REG_STATUS  5'h0c
`define PCM_CTRL_RST    10'h2ba
`define PCM_SYS_HZ      40000000
`define PCM_BCLK_MIN_HZ 256000
`define PCM_FS_HZ       48000
`define PCM_MCLK_RATIO  256
`define PCM_ACC_W       24
`define PCM_WORD_BITS   16
`define PCM_LOG_BASE    3
`define PCM_RESP_OKAY   2'h0
`define PCM_RESP_SLVERR 2'h2
`endif

// File: verilog/pcm_pkg.sv
// Types of the audio port: control word and register state
package pcm_pkg;
	typedef struct packed {
		logic       mclk_en;
		logic       fs16;
		logic [2:0] frame;
		logic [1:0] rate;
		logic       long_sync;
		logic       master;
		logic       enable;
	} pcm_ctrl_t;

	typedef struct packed {
		pcm_ctrl_t   ctrl;
		logic        aw_got;
		logic [4:0]  awaddr;
		logic        w_got;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [15:0] tx_buf;
		logic        tx_full;
		logic [15:0] sh_tx;
		logic [15:0] sh_rx;
		logic [15:0] rx_word;
		logic        rx_rdy;
		logic        rx_ovr;
		logic [7:0]  slot;
		logic        bclk;
		logic        sync;
		logic [1:0]  clk_s;
		logic [1:0]  sync_s;
		logic [1:0]  din_s;
		logic        clk_p;
		logic        sync_p;
		logic [23:0] bacc;
		logic [23:0] racc;
		logic        mclk;
	} pcm_st_t;
endpackage

// File: verilog/pcm_port.sv
// PCM digital audio serial port with AXI4-Lite registers
// What this block does
// - Master drives bit clock and sync, slave follows
// - Short or long frame sync, selectable
// - Sixteen-bit linear PCM words both directions
// - Bit clock 256k to 2048k, 2048k default
// - Frame of 8 to 256 bit clocks
// - Frame rate set by bit clock and frame, checked against 8 kHz or 16 kHz
// - Reference clock out, 12.288 MHz default
// - Reference clock is 256 times 48 kHz
// - Reference clock usable apart from audio port
`timescale 1ns/1ps
`include "pcm_map.svh"
module pcm_port import pcm_pkg::*; (
	input  wire logic        ref_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [4:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	input  wire logic        pcm_clk_i,
	output logic             pcm_clk_o,
	output logic             pcm_clk_oe_o,
	input  wire logic        pcm_sync_i,
	output logic             pcm_sync_o,
	output logic             pcm_sync_oe_o,
	input  wire logic        pcm_din_i,
	output logic             pcm_dout_o,
	output logic             mclk_o
);
	// Half-period steps of the lowest bit clock and of the reference clock
	localparam logic [63:0] BINC = 64'((64'd2 * `PCM_BCLK_MIN_HZ
		<< `PCM_ACC_W) / `PCM_SYS_HZ);
	localparam logic [63:0] RINC = 64'((64'd2 * `PCM_MCLK_RATIO
		* `PCM_FS_HZ << `PCM_ACC_W) / `PCM_SYS_HZ);

	pcm_st_t s;
	pcm_st_t n;
	logic    rise_ev;
	logic    fall_ev;
	logic    mismatch;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic mapped(input logic [4:0] a);
		return a == `PCM_REG_CTRL || a == `PCM_REG_TXDATA ||
			a == `PCM_REG_RXDATA || a == `PCM_REG_STATUS;
	endfunction

	logic [7:0] last;
	logic [7:0] half;
	logic [7:0] nslot;
	logic [24:0] bsum;
	logic [24:0] rsum;
	assign last = 8'((9'd8 << s.ctrl.frame) - 9'd1);
	assign half = 8'((9'd4 << s.ctrl.frame) - 9'd1);
	assign nslot = (s.slot == last) ? 8'h00 : 8'(s.slot + 8'h01);
	// Frame length must equal bit rate over sample rate
	assign mismatch = ({1'b0, s.ctrl.frame} + 4'(`PCM_LOG_BASE)) !=
		(4'(s.ctrl.rate) + 4'h5 - 4'(s.ctrl.fs16));

	always_comb begin
		n = s;
		n.clk_s = {s.clk_s[0], pcm_clk_i};
		n.sync_s = {s.sync_s[0], pcm_sync_i};
		n.din_s = {s.din_s[0], pcm_din_i};
		n.clk_p = s.clk_s[1];
		// Reference clock runs whatever the audio port does
		rsum = {1'b0, s.racc} + 25'(RINC);
		n.racc = rsum[23:0];
		if (!s.ctrl.mclk_en) begin
			n.mclk = 1'b0;
		end else if (rsum[24]) begin
			n.mclk = ~s.mclk;
		end
		bsum = {1'b0, s.bacc} + 25'(BINC[23:0] << s.ctrl.rate);
		n.bacc = bsum[23:0];
		if (s.ctrl.master) begin
			rise_ev = bsum[24] & ~s.bclk & s.ctrl.enable;
			fall_ev = bsum[24] & s.bclk;
		end else begin
			rise_ev = s.clk_s[1] & ~s.clk_p & s.ctrl.enable;
			fall_ev = ~s.clk_s[1] & s.clk_p & s.ctrl.enable;
		end
		if (rise_ev | fall_ev) begin
			n.bclk = rise_ev;
		end
		// Register reads; RXDATA read clears its flags before new events
		if (s_axi_arvalid && !s.rvalid) begin
			n.rvalid = 1'b1;
			n.rresp = mapped(s_axi_araddr) ? `PCM_RESP_OKAY
				: `PCM_RESP_SLVERR;
			unique case (s_axi_araddr)
			`PCM_REG_CTRL: n.rdata = {22'h0, s.ctrl};
			`PCM_REG_RXDATA: begin
				n.rdata = {16'h0, s.rx_word};
				n.rx_rdy = 1'b0;
				n.rx_ovr = 1'b0;
			end
			`PCM_REG_STATUS: n.rdata = {16'h0, s.slot, 4'h0, mismatch,
				s.rx_ovr, s.tx_full, s.rx_rdy};
			default: n.rdata = 32'h0;
			endcase
		end else if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (rise_ev) begin
			n.slot = nslot;
			if (nslot == 8'h00) begin
				n.sh_tx = s.tx_full ? s.tx_buf : 16'h0;
				n.tx_full = 1'b0;
			end else begin
				n.sh_tx = {s.sh_tx[14:0], 1'b0};
			end
			if (s.ctrl.long_sync) begin
				n.sync = nslot <= half;
			end else begin
				n.sync = nslot == last;
			end
		end
		if (fall_ev) begin
			n.sync_p = s.sync_s[1];
			if (s.slot < 8'(`PCM_WORD_BITS)) begin
				n.sh_rx = {s.sh_rx[14:0], s.din_s[1]};
			end
			if (s.slot == 8'(`PCM_WORD_BITS - 1)) begin
				n.rx_word = {s.sh_rx[14:0], s.din_s[1]};
				n.rx_rdy = 1'b1;
				n.rx_ovr = n.rx_ovr | s.rx_rdy;
			end
			// Slave realigns its slot count to the codec's sync
			if (!s.ctrl.master && s.sync_s[1]) begin
				if (!s.ctrl.long_sync) begin
					n.slot = last;
				end else if (!s.sync_p) begin
					n.slot = 8'h00;
				end
			end
		end
		if (!s.ctrl.enable) begin
			n.bclk = 1'b0;
			n.sync = 1'b0;
			n.slot = last;
		end
		// Write address and data taken in either order
		if (s_axi_awvalid && !s.aw_got && !s.bvalid) begin
			n.aw_got = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s.w_got && !s.bvalid) begin
			n.w_got = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (s.aw_got && s.w_got) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = mapped(s.awaddr) ? `PCM_RESP_OKAY : `PCM_RESP_SLVERR;
			if (s.awaddr == `PCM_REG_CTRL) begin
				n.ctrl = pcm_ctrl_t'(10'(merge({22'h0, s.ctrl}, s.wdata,
					s.wstrb)));
			end
			if (s.awaddr == `PCM_REG_TXDATA) begin
				n.tx_buf = 16'(merge({16'h0, s.tx_buf}, s.wdata, s.wstrb));
				n.tx_full = 1'b1;
			end
		end else if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s <= '0;
			s.ctrl <= pcm_ctrl_t'(`PCM_CTRL_RST);
			s.slot <= 8'hff;
		end else begin
			s <= n;
		end
	end

	assign s_axi_awready = !s.aw_got && !s.bvalid;
	assign s_axi_wready = !s.w_got && !s.bvalid;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign pcm_clk_o = s.bclk;
	assign pcm_sync_o = s.sync;
	assign pcm_clk_oe_o = s.ctrl.master && s.ctrl.enable;
	assign pcm_sync_oe_o = s.ctrl.master && s.ctrl.enable;
	assign pcm_dout_o = s.sh_tx[15];
	assign mclk_o = s.mclk;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);

	AST_MASTER_DRIVES: assert property (
		pcm_clk_oe_o == (s.ctrl.master && s.ctrl.enable)
		&& pcm_sync_oe_o == pcm_clk_oe_o && (s.ctrl.master || !rise_ev
		|| $past(s.clk_s[1]) == 1'b0))
		else $error("bit clock drive does not follow mode");
	AST_SHORT_SYNC_END: assert property (
		s.ctrl.master && s.ctrl.enable && !s.ctrl.long_sync && rise_ev
		|=> !$stable(s.ctrl) || pcm_sync_o == (s.slot == last))
		else $error("short sync not confined to last slot");
	AST_RX_WORD: assert property (
		$rose(s.rx_rdy) |-> $past(s.slot) == 8'h0f && $past(fall_ev))
		else $error("received word not closed at bit fifteen");
	AST_BCLK_HALF: assert property (
		s.ctrl.master && s.ctrl.enable && s.ctrl.rate == 2'h3
		&& $changed(pcm_clk_o) |=> ($stable(pcm_clk_o) || !s.ctrl.master
		|| !s.ctrl.enable || s.ctrl.rate != 2'h3)[*8])
		else $error("bit clock half period too short");
	AST_FRAME_WRAP: assert property (
		rise_ev && s.slot == last && s.ctrl.master |=> s.slot == 8'h00)
		else $error("slot counter missed frame end");
	AST_MCLK_RUNS: assert property (
		s.ctrl.mclk_en && $past(s.ctrl.mclk_en) |-> ##[0:2]
		$changed(mclk_o))
		else $error("reference clock stalled");
	AST_MCLK_FREE: assert property (
		s.ctrl.mclk_en && !s.ctrl.enable ##1 s.ctrl.mclk_en |->
		##[0:2] $changed(mclk_o))
		else $error("reference clock tied to audio enable");
	AST_TX_MSB: assert property (
		rise_ev && nslot == 8'h00 && s.tx_full |=>
		pcm_dout_o == $past(s.tx_buf[15]))
		else $error("transmit MSB not first in frame");
	AST_BRESP_HOLD: assert property (
		s.bvalid && !s_axi_bready |=> s.bvalid && $stable(s.bresp))
		else $error("write response dropped early");
endmodule // pcm_port

// File: tb/pcm_codec.sv
// Behavioural codec at the far end of the PCM link
`timescale 1ns/1ps
module pcm_codec (
	input  wire logic        drive_i,
	input  wire logic        long_i,
	input  wire logic [8:0]  bits_i,
	input  wire logic [15:0] word_i,
	input  wire logic        clk_i,
	input  wire logic        sync_i,
	input  wire logic        dout_i,
	output logic             clk_o,
	output logic             sync_o,
	output logic             din_o,
	output logic [15:0]      rx_o,
	output int               cnt_o
);
	int          bn = 99;
	int          gs = 0;
	logic        ps = 0;
	logic        ss = 0;
	logic [15:0] sh = '0;
	initial begin
		{clk_o, sync_o, din_o} = '0;
		rx_o = '0;
		cnt_o = 0;
		forever #100 clk_o = drive_i & ~clk_o;
	end
	always @(posedge clk_o) begin
		gs = (gs + 1) % bits_i;
		sync_o <= long_i ? gs < bits_i / 2 : gs == bits_i - 1;
	end
	// Frame start is judged after the edge so sync has settled
	always @(posedge clk_i) begin
		#5;
		bn = (long_i ? sync_i & ~ps : ss) ? 0 : bn + 1;
		ps = sync_i;
		din_o = bn < 16 ? word_i[15 - bn] : 1'b0;
	end
	always @(negedge clk_i) begin
		ss = sync_i;
		if (bn < 16)
			sh = {sh[14:0], dout_i};
		if (bn == 15) begin
			rx_o = sh;
			cnt_o++;
		end
	end
endmodule // pcm_codec

// File: tb/tb_pcm_port.sv
// Self-checking bench of the PCM audio port
`timescale 1ns/1ps
`include "pcm_map.svh"
module tb_pcm_port;
	logic        ref_clk_i, nrst_i, awv, awr, wv, wr, bv, bry;
	logic        arv, arr, rv, rry, ck_o, ck_oe, sy_o, sy_oe;
	logic        dout, din, mclk, c_ck, c_sy, c_drv, c_long;
	logic [4:0]  awa, ara;
	logic [31:0] wd, rd, d0;
	logic [1:0]  br, rr, rs;
	logic [8:0]  c_bits;
	logic [15:0] c_word, c_rx;
	int          c_cnt, error_cnt, compares, cyc, mcnt, t;
	wire         ck_l = ck_oe ? ck_o : c_ck;
	wire         sy_l = sy_oe ? sy_o : c_sy;
	pcm_port dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.s_axi_rdata(rd), .s_axi_rresp(rr), .pcm_clk_i(ck_l),
		.pcm_clk_o(ck_o), .pcm_clk_oe_o(ck_oe), .pcm_sync_i(sy_l),
		.pcm_sync_o(sy_o), .pcm_sync_oe_o(sy_oe), .pcm_din_i(din),
		.pcm_dout_o(dout), .mclk_o(mclk));
	pcm_codec codec (.drive_i(c_drv), .long_i(c_long), .bits_i(c_bits),
		.word_i(c_word), .clk_i(ck_l), .sync_i(sy_l), .dout_i(dout),
		.clk_o(c_ck), .sync_o(c_sy), .din_o(din), .rx_o(c_rx),
		.cnt_o(c_cnt));
	initial begin
		ref_clk_i = 0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge mclk) mcnt++;
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 100000) begin
			error_cnt++;
			print_verdict;
		end
	end
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [33:0] s, e);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic axw(input logic [4:0] a, input logic [31:0] d);
		{awa, wd, awv, wv, bry} <= {a, d, 3'b111};
		do begin
			@(posedge ref_clk_i);
			if (awr)
				awv <= 0;
			if (wr)
				wv <= 0;
		end while (!bv);
		bry <= 0;
		chk("bresp", br, `PCM_RESP_OKAY);
		@(posedge ref_clk_i);
	endtask
	task automatic axr(input logic [4:0] a, output logic [31:0] d);
		{ara, arv, rry} <= {a, 2'b11};
		do begin
			@(posedge ref_clk_i);
			if (arr)
				arv <= 0;
		end while (!rv);
		d = rd;
		rs = rr;
		rry <= 0;
		@(posedge ref_clk_i);
	endtask
	task automatic poll(input int b, v);
		logic [31:0] s;
		do axr(`PCM_REG_STATUS, s); while (s[b] !== v);
	endtask
	task automatic mclk_cnt(input int lo, hi);
		t = mcnt;
		repeat (1000) @(posedge ref_clk_i);
		chk("mclk", (mcnt - t) inside {[lo:hi]}, 1);
	endtask
	task automatic run(input logic [9:0] cv);
		logic [15:0] w;
		int          e;
		c_bits = 9'd8 << cv[7:5];
		{c_long, c_drv} = {cv[2], ~cv[1]};
		c_word = $urandom;
		axw(`PCM_REG_CTRL, {22'h0, cv});
		t = c_cnt + 2;
		wait (c_cnt >= t);
		chk("clk_oe", ck_oe, cv[1]);
		chk("sync_oe", sy_oe, cv[1]);
		axr(`PCM_REG_RXDATA, d0);
		poll(0, 1);
		axr(`PCM_REG_RXDATA, d0);
		chk("rx_word", d0, c_word);
		axr(`PCM_REG_STATUS, d0);
		chk("mismatch", d0[3], (c_bits * (8000 << cv[8])) != (256000 << cv[4:3]));
		if (cv[1]) begin
			w = $urandom;
			axw(`PCM_REG_TXDATA, {16'h0, w});
			poll(1, 0);
			t = c_cnt + 1;
			wait (c_cnt == t);
			chk("tx_word", c_rx, w);
			wait (c_cnt == t + 1);
			chk("idle_word", c_rx, 0);
			e = c_bits * 15625 / (100 << cv[4:3]);
			@(posedge sy_l);
			t = cyc;
			@(posedge sy_l);
			chk("frame_len", (cyc - t - e + 2) inside {[0:4]}, 1);
		end
		$display("test %h done", cv);
	endtask
	initial begin
		{nrst_i, awv, wv, bry, arv, rry, c_drv, c_long} = '0;
		{awa, ara, wd, c_word} = '0;
		c_bits = 16;
		void'($urandom(32'heb3c));
		repeat (12) @(posedge ref_clk_i);
		nrst_i <= 1;
		@(posedge ref_clk_i);
		axr(`PCM_REG_CTRL, d0);
		chk("ctrl_rst", d0, `PCM_CTRL_RST);
		axr(5'h10, d0);
		chk("unmapped", {rs, d0}, {`PCM_RESP_SLVERR, 32'h0});
		mclk_cnt(306, 308);
		axw(`PCM_REG_CTRL, 32'h0ba);
		repeat (4) @(posedge ref_clk_i);
		mclk_cnt(0, 0);
		$display("test mclk done");
		run(10'h23b);
		run(10'h257);
		run(10'h32b);
		run(10'h227);
		run(10'h2bb);
		run(10'h239);
		print_verdict;
	end
endmodule // tb_pcm_port
